// *** design/brc_map.vh ***
// Register indices, field positions, reset values and timing constants of the buck control bank.
`ifndef BRC_MAP_VH
`define BRC_MAP_VH

// Register indices; the byte address is four times the index.
`define BRC_IDX_B5_MODES    8'h47
`define BRC_IDX_B5_REQ      8'h48
`define BRC_IDX_B5_FORCE    8'h49
`define BRC_IDX_B5_VOLT     8'h4a
`define BRC_IDX_B5_STEP     8'h4b
`define BRC_IDX_B1_MODES    8'h53
`define BRC_IDX_B1_REQ      8'h54
`define BRC_IDX_B1_FORCE    8'h55
`define BRC_IDX_B1_VOLT     8'h56
`define BRC_IDX_B1_STEP     8'h57
`define BRC_IDX_B2_MODES    8'h59
`define BRC_IDX_B2_REQ      8'h5a
`define BRC_IDX_B2_FORCE    8'h5b
`define BRC_IDX_B2_VOLT     8'h5c
`define BRC_IDX_B2_STEP     8'h5d

// Mode command encodings.
`define BRC_MODE_OFF        2'b00
`define BRC_MODE_AUTO       2'b01
`define BRC_MODE_FPWM       2'b11

// Resource state request encodings.
`define BRC_REQ_OFF0        2'b00
`define BRC_REQ_ON          2'b01
`define BRC_REQ_OFF1        2'b10
`define BRC_REQ_SLEEP       2'b11

// Forced dynamic-voltage command encodings.
`define BRC_CMD_FACT        2'b00
`define BRC_CMD_ACT         2'b01
`define BRC_CMD_FSLP        2'b10
`define BRC_CMD_SLEEP       2'b11

// Power state machine state encodings on psm_state.
`define BRC_PSM_OFF         2'b00
`define BRC_PSM_SLEEP       2'b01
`define BRC_PSM_ACTIVE      2'b10

// Field positions.
`define BRC_MODES_SLP_LO    2
`define BRC_MODES_ACT_HI    1
`define BRC_MODES_ACT_LO    0
`define BRC_CMD_HI          7
`define BRC_CMD_LO          6
`define BRC_CODE_HI         5
`define BRC_WRS_BIT         7
`define BRC_NOSTEP_BIT      7
`define BRC_STEP_HI         4
`define BRC_REQ_HI          1
`define BRC_ADDR_IDX_HI     9
`define BRC_ADDR_IDX_LO     2

// Reset values.
`define BRC_RST_SLP_LO      1'b1
`define BRC_RST_ACT_HI      1'b0
`define BRC_RST_STEP        5'b0_0110
`define BRC_STEP_MIN        5'b0_0110
`define BRC_CODE_ZERO       6'h00

// Ramp time base: pclk rate and ramp clock rate in kHz.
`define BRC_PCLK_KHZ        200000
`define BRC_RAMP_KHZ        6000
`define BRC_TICK_DIV        (`BRC_PCLK_KHZ / `BRC_RAMP_KHZ)
`define BRC_PRESC_W         6

`endif

// *** design/brc_regs.v ***
// Buck regulator control register bank with APB access, mode selection and voltage ramping.
`timescale 1ns/10ps
`default_nettype none
`include "brc_map.vh"

module brc_regs (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Power state machine, same clock domain.
  input  wire [1:0]  psm_state,
  input  wire        psm_wait_on_entry,
  input  wire        warm_reset_pulse,
  input  wire        state_reset_pulse,
  // Factory defaults, buck5 in bits 5:0, buck1 in 11:6, buck2 in 17:12.
  input  wire [17:0] nvm_force_code,
  input  wire [17:0] nvm_normal_code,
  // Regulator controls, same packing.
  output wire [17:0] buck_voltage_code,
  output wire [5:0]  buck_op_mode,
  output wire [2:0]  buck_enable,
  output wire [2:0]  buck_sleep
);

  reg  [31:0]          prdata_reg;
  reg                  pready_reg;
  reg                  pslverr_reg;
  reg                  loaded_reg;
  reg  [`BRC_PRESC_W-1:0] presc_reg;
  reg                  tick_reg;
  wire [7:0]           rd_bus [0:2];
  wire [2:0]           hit_bus;
  wire [7:0]           idx;
  wire                 aligned;
  wire                 acc_start;
  wire                 wr_now;
  wire                 any_hit;
  wire [7:0]           rd_data;
  wire                 load_defaults;

  assign idx           = paddr[`BRC_ADDR_IDX_HI:`BRC_ADDR_IDX_LO];
  assign aligned       = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign acc_start     = psel && penable && !pready_reg;
  assign wr_now        = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign any_hit       = aligned && (|hit_bus);
  assign rd_data       = rd_bus[0] | rd_bus[1] | rd_bus[2];
  assign load_defaults = !loaded_reg || psm_wait_on_entry;

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // The access phase lasts two cycles; writes land on the edge that samples pready.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (acc_start) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !any_hit;
      prdata_reg  <= (any_hit && !pwrite) ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Defaults are caught one cycle after reset release, since an async reset may only load constants.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  // Ramp time base: one pulse per 6 MHz period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= {`BRC_PRESC_W{1'b0}};
      tick_reg  <= 1'b0;
    end else if (presc_reg == `BRC_TICK_DIV - 1) begin
      presc_reg <= {`BRC_PRESC_W{1'b0}};
      tick_reg  <= 1'b1;
    end else begin
      presc_reg <= presc_reg + 1'b1;
      tick_reg  <= 1'b0;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_buck
      localparam [7:0] IDX_MODES = (i == 0) ? `BRC_IDX_B5_MODES : (i == 1) ? `BRC_IDX_B1_MODES : `BRC_IDX_B2_MODES;
      localparam [7:0] IDX_REQ   = (i == 0) ? `BRC_IDX_B5_REQ   : (i == 1) ? `BRC_IDX_B1_REQ   : `BRC_IDX_B2_REQ;
      localparam [7:0] IDX_FORCE = (i == 0) ? `BRC_IDX_B5_FORCE : (i == 1) ? `BRC_IDX_B1_FORCE : `BRC_IDX_B2_FORCE;
      localparam [7:0] IDX_VOLT  = (i == 0) ? `BRC_IDX_B5_VOLT  : (i == 1) ? `BRC_IDX_B1_VOLT  : `BRC_IDX_B2_VOLT;
      localparam [7:0] IDX_STEP  = (i == 0) ? `BRC_IDX_B5_STEP  : (i == 1) ? `BRC_IDX_B1_STEP  : `BRC_IDX_B2_STEP;

      reg        slp_lo_reg;
      reg        act_hi_reg;
      reg  [1:0] req_reg;
      reg  [1:0] saved_req_reg;
      reg  [1:0] cmd_reg;
      reg  [5:0] fcode_reg;
      reg        wrs_reg;
      reg  [5:0] ncode_reg;
      reg        nostep_reg;
      reg  [4:0] step_reg;
      reg  [5:0] applied_reg;
      reg  [4:0] tick_cnt_reg;
      reg  [1:0] mode_reg;
      reg        enable_reg;
      reg        sleep_reg;
      reg  [7:0] rd_sel;
      reg        hit_sel;
      reg        reg_off;
      reg        reg_sleep;
      reg        forced;
      reg  [5:0] target;
      reg  [1:0] mode_next;
      wire [5:0] nvm_f;
      wire [5:0] nvm_n;
      wire [4:0] step_dly;
      wire       wr_modes;
      wire       wr_req;
      wire       wr_force;
      wire       wr_volt;
      wire       wr_step;

      assign nvm_f    = nvm_force_code[i*6 +: 6];
      assign nvm_n    = nvm_normal_code[i*6 +: 6];
      assign wr_modes = wr_now && (idx == IDX_MODES);
      assign wr_req   = wr_now && (idx == IDX_REQ);
      assign wr_force = wr_now && (idx == IDX_FORCE);
      assign wr_volt  = wr_now && (idx == IDX_VOLT);
      assign wr_step  = wr_now && (idx == IDX_STEP);
      assign step_dly = (step_reg < `BRC_STEP_MIN) ? `BRC_STEP_MIN : step_reg;

      always @* begin
        hit_sel = 1'b1;
        rd_sel  = 8'h00;
        case (idx)
          IDX_MODES: rd_sel = {5'b0_0000, slp_lo_reg, act_hi_reg, 1'b1};
          IDX_REQ:   rd_sel = {6'b00_0000, req_reg};
          IDX_FORCE: rd_sel = {cmd_reg, fcode_reg};
          IDX_VOLT:  rd_sel = {wrs_reg, 1'b0, ncode_reg};
          IDX_STEP:  rd_sel = {nostep_reg, 2'b00, step_reg};
          default:   hit_sel = 1'b0;
        endcase
      end
      assign rd_bus[i]  = (aligned && hit_sel) ? rd_sel : 8'h00;
      assign hit_bus[i] = hit_sel;

      // Effective regulator state from request, force command and power state.
      always @* begin
        reg_off   = 1'b0;
        reg_sleep = 1'b0;
        forced    = 1'b0;
        case (req_reg)
          `BRC_REQ_OFF0: begin
            reg_off = 1'b1;
          end
          `BRC_REQ_OFF1: begin
            reg_off = 1'b1;
          end
          `BRC_REQ_SLEEP: begin
            reg_sleep = 1'b1;
          end
          default: begin
            reg_sleep = 1'b0;
          end
        endcase
        // A forced sleep with a zero force code means off, so that code never becomes a forced-sleep target.
        case (cmd_reg)
          `BRC_CMD_FACT: begin
            forced = 1'b1;
          end
          `BRC_CMD_FSLP: begin
            if (fcode_reg == `BRC_CODE_ZERO) begin
              reg_off = 1'b1;
            end else begin
              reg_sleep = 1'b1;
              forced    = 1'b1;
            end
          end
          `BRC_CMD_SLEEP: begin
            reg_sleep = 1'b1;
          end
          default: begin
            forced = 1'b0;
          end
        endcase
        case (psm_state)
          `BRC_PSM_OFF: begin
            reg_off = 1'b1;
          end
          `BRC_PSM_SLEEP: begin
            reg_sleep = 1'b1;
          end
          default: ;
        endcase
        target    = forced ? fcode_reg : ncode_reg;
        if (reg_off) begin
          mode_next = `BRC_MODE_OFF;
        end else if (reg_sleep) begin
          mode_next = {1'b0, slp_lo_reg};
        end else begin
          mode_next = {act_hi_reg, 1'b1};
        end
      end

      // Configuration domain: modes and ramp step, cleared by a warm reset.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slp_lo_reg <= `BRC_RST_SLP_LO;
          act_hi_reg <= `BRC_RST_ACT_HI;
          nostep_reg <= 1'b0;
          step_reg   <= `BRC_RST_STEP;
        end else if (warm_reset_pulse) begin
          slp_lo_reg <= `BRC_RST_SLP_LO;
          act_hi_reg <= `BRC_RST_ACT_HI;
          nostep_reg <= 1'b0;
          step_reg   <= `BRC_RST_STEP;
        end else begin
          if (wr_modes) begin
            slp_lo_reg <= pwdata[`BRC_MODES_SLP_LO];
            act_hi_reg <= pwdata[`BRC_MODES_ACT_HI];
          end
          if (wr_step) begin
            nostep_reg <= pwdata[`BRC_NOSTEP_BIT];
            step_reg   <= pwdata[`BRC_STEP_HI:0];
          end
        end
      end

      // State domain: request and force register; backup domain: warm-reset sensitivity.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          req_reg       <= `BRC_REQ_OFF0;
          saved_req_reg <= `BRC_REQ_OFF0;
          cmd_reg       <= `BRC_CMD_FACT;
          fcode_reg     <= `BRC_CODE_ZERO;
          wrs_reg       <= 1'b0;
          ncode_reg     <= `BRC_CODE_ZERO;
        end else begin
          if (state_reset_pulse || warm_reset_pulse) begin
            req_reg <= `BRC_REQ_OFF0;
            cmd_reg <= `BRC_CMD_FACT;
          end else if (wr_req) begin
            req_reg <= pwdata[`BRC_REQ_HI:0];
          end else if (wr_force) begin
            cmd_reg <= pwdata[`BRC_CMD_HI:`BRC_CMD_LO];
          end else if (wr_volt && (pwdata[`BRC_CODE_HI:0] == `BRC_CODE_ZERO)) begin
            saved_req_reg <= req_reg;
            req_reg       <= `BRC_REQ_OFF0;
          end else if (wr_volt && (ncode_reg == `BRC_CODE_ZERO)) begin
            req_reg <= saved_req_reg;
          end
          if (load_defaults || state_reset_pulse) begin
            fcode_reg <= nvm_f;
          end else if (wr_force) begin
            fcode_reg <= pwdata[`BRC_CODE_HI:0];
          end
          if (load_defaults) begin
            ncode_reg <= nvm_n;
          end else if (warm_reset_pulse) begin
            if (!wrs_reg) begin
              ncode_reg <= nvm_n;
            end
          end else if (wr_volt) begin
            ncode_reg <= pwdata[`BRC_CODE_HI:0];
            wrs_reg   <= pwdata[`BRC_WRS_BIT];
          end
        end
      end

      // Applied outputs follow the power state every cycle and ramp the voltage code.
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          applied_reg  <= `BRC_CODE_ZERO;
          tick_cnt_reg <= 5'b0_0000;
          mode_reg     <= `BRC_MODE_OFF;
          enable_reg   <= 1'b0;
          sleep_reg    <= 1'b0;
        end else begin
          mode_reg   <= mode_next;
          enable_reg <= !reg_off;
          sleep_reg  <= !reg_off && reg_sleep;
          if (!loaded_reg) begin
            tick_cnt_reg <= 5'b0_0000;
          end else if (nostep_reg) begin
            applied_reg  <= target;
            tick_cnt_reg <= 5'b0_0000;
          end else if (applied_reg == target) begin
            tick_cnt_reg <= 5'b0_0000;
          end else if (tick_reg) begin
            if (tick_cnt_reg + 5'b0_0001 >= step_dly) begin
              tick_cnt_reg <= 5'b0_0000;
              if (applied_reg < target) begin
                applied_reg <= applied_reg + 6'h01;
              end else begin
                applied_reg <= applied_reg - 6'h01;
              end
            end else begin
              tick_cnt_reg <= tick_cnt_reg + 5'b0_0001;
            end
          end
        end
      end

      assign buck_voltage_code[i*6 +: 6] = applied_reg;
      assign buck_op_mode[i*2 +: 2]      = mode_reg;
      assign buck_enable[i]              = enable_reg;
      assign buck_sleep[i]               = sleep_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// *** verif/brc_checker.sv ***
// Port checks for the buck control register bank.
`timescale 1ns/10ps
`default_nettype none
`include "brc_map.vh"
module brc_checker (
  // Clock, reset and APB.
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Power state machine and defaults.
  input wire [1:0]  psm_state,
  input wire        psm_wait_on_entry,
  input wire        warm_reset_pulse,
  input wire        state_reset_pulse,
  input wire [17:0] nvm_force_code,
  input wire [17:0] nvm_normal_code,
  // Regulator controls.
  input wire [17:0] buck_voltage_code,
  input wire [5:0]  buck_op_mode,
  input wire [2:0]  buck_enable,
  input wire [2:0]  buck_sleep
);
  logic [5:0] last_reg;
  logic [7:0] gap_reg;
  logic       nostep_reg;
  logic       ramp_reg;
  wire        moved = buck_voltage_code[5:0] != last_reg;

  // Mirrors the buck5 no-ramp bit so that direct jumps are not taken for ramp steps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg   <= 6'h00;
      gap_reg    <= 8'h00;
      nostep_reg <= 1'b0;
      ramp_reg   <= 1'b0;
    end else begin
      last_reg <= buck_voltage_code[5:0];
      gap_reg  <= moved ? 8'h00 : gap_reg + {7'h00, gap_reg != 8'hff};
      if (warm_reset_pulse)
        nostep_reg <= 1'b0;
      else if (psel && penable && pready && pwrite && !pslverr && paddr[9:2] == `BRC_IDX_B5_STEP)
        nostep_reg <= pwdata[7];
      if (moved)
        ramp_reg <= !nostep_reg;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    setup_s ##1 psel && penable;
  endsequence
  sequence answer_s;
    !pready ##1 pready ##1 !pready;
  endsequence
  sequence mode_read_s;
    pready && !pwrite && !pslverr && paddr[9:2] == `BRC_IDX_B5_MODES;
  endsequence
  sequence sleep_applied_s;
    buck_op_mode[5] == 1'b0 && buck_op_mode[3] == 1'b0 && buck_op_mode[1] == 1'b0 && buck_sleep == buck_enable;
  endsequence
  sequence one_code_s;
    buck_voltage_code[5:0] == last_reg + 6'd1 || buck_voltage_code[5:0] + 6'd1 == last_reg;
  endsequence

  apb_answer_a: assert property (access_s |-> answer_s)
    else $error("apb answer out of place");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  misalign_err_a: assert property (psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  mode_read_a: assert property (mode_read_s |-> prdata[0] && prdata[31:3] == 29'h0)
    else $error("mode register fixed bits wrong");
  off_mode_a: assert property (psm_state == `BRC_PSM_OFF |=> buck_op_mode == 6'h00 && buck_enable == 3'h0)
    else $error("regulator not off in off state");
  sleep_on_a: assert property ((buck_sleep & ~buck_enable) == 3'h0)
    else $error("sleep without enable");
  sleep_mode_a: assert property (psm_state == `BRC_PSM_SLEEP |=> sleep_applied_s)
    else $error("sleep state mode not applied");
  ramp_delta_a: assert property (moved && !nostep_reg |-> one_code_s)
    else $error("ramp step larger than one code");
  ramp_gap_a: assert property (moved && !nostep_reg && ramp_reg |-> gap_reg >= 8'd196)
    else $error("ramp steps too close");
endmodule

bind brc_regs brc_checker u_brc_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psm_state(psm_state),
  .psm_wait_on_entry(psm_wait_on_entry), .warm_reset_pulse(warm_reset_pulse),
  .state_reset_pulse(state_reset_pulse), .nvm_force_code(nvm_force_code), .nvm_normal_code(nvm_normal_code),
  .buck_voltage_code(buck_voltage_code), .buck_op_mode(buck_op_mode), .buck_enable(buck_enable),
  .buck_sleep(buck_sleep)
);
`default_nettype wire

// *** verif/test_buck_regulator_control_regs.sv ***
// Self-checking bench for the buck control register bank.
`timescale 1ns/10ps
`default_nettype none
`include "brc_map.vh"
module test_buck_regulator_control_regs;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  logic [1:0]  psm_state;
  logic [2:0]  pulses;
  logic [17:0] nvm_force_code;
  logic [17:0] nvm_normal_code;
  wire  [17:0] buck_voltage_code;
  wire  [5:0]  buck_op_mode;
  wire  [2:0]  buck_enable;
  wire  [2:0]  buck_sleep;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [7:0]  seed;
  int          mismatches;
  int          tests_run;
  int          n;
  int          m;
  localparam logic [7:0] BASES[3] = '{`BRC_IDX_B5_MODES, `BRC_IDX_B1_MODES, `BRC_IDX_B2_MODES};
  localparam logic [7:0] REQX[4]  = '{8'h00, 8'h0e, 8'h00, 8'h07};
  localparam logic [7:0] FRC[5]   = '{8'h0e, 8'h4e, 8'hce, 8'h80, 8'h8e};
  localparam logic [7:0] FRX[5]   = '{8'h0e, 8'h0e, 8'h07, 8'h00, 8'h07};
  localparam logic [1:0] PSM[3]   = '{`BRC_PSM_ACTIVE, `BRC_PSM_SLEEP, `BRC_PSM_OFF};
  localparam logic [7:0] PSX[3]   = '{8'h0e, 8'h07, 8'h00};

  brc_regs DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psm_state(psm_state),
    .psm_wait_on_entry(pulses[2]), .warm_reset_pulse(pulses[1]), .state_reset_pulse(pulses[0]),
    .nvm_force_code(nvm_force_code), .nvm_normal_code(nvm_normal_code),
    .buck_voltage_code(buck_voltage_code), .buck_op_mode(buck_op_mode), .buck_enable(buck_enable),
    .buck_sleep(buck_sleep)
  );

  task automatic cmp_bus(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // For a read, d is the expected byte; for a write it is the byte written.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic err,
                     input logic [1:0] lo = 2'b00);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, lo};
    pwdata <= {24'h00_0000, d};
    exp_q.push_back({!wr, err, 24'h00_0000, wr ? 8'h00 : d});
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic volt, input logic [7:0] exp, input int b = 0);
    repeat (2) @(posedge pclk);
    #1;
    cmp_out(volt ? {2'b00, buck_voltage_code[6*b +: 6]}
                 : {4'h0, buck_op_mode[2*b +: 2], buck_enable[b], buck_sleep[b]}, exp);
    @(posedge pclk);
  endtask

  task automatic pulse(input logic [2:0] s);
    @(posedge pclk);
    pulses <= s;
    @(posedge pclk);
    pulses <= 3'b000;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wrap_up;
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[33])
        cmp_bus({pslverr, prdata}, e[32:0]);
      else
        cmp_bus({pslverr, 32'h0000_0000}, {e[32], 32'h0000_0000});
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, pulses} = 6'h00;
    paddr           = 12'h000;
    pwdata          = 32'h0000_0000;
    psm_state       = `BRC_PSM_ACTIVE;
    nvm_force_code  = {6'h25, 6'h17, 6'h0e};
    nvm_normal_code = {6'h20, 6'h18, 6'h0c};
    mismatches      = 0;
    tests_run       = 0;
    seed            = 8'h5f;
    presetn         = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int b = 0; b < 3; b++) begin
      apb(1'b0, BASES[b], 8'h05, 1'b0);
      apb(1'b0, BASES[b] + 8'd1, 8'h00, 1'b0);
      apb(1'b0, BASES[b] + 8'd2, {2'b00, nvm_force_code[6*b +: 6]}, 1'b0);
      apb(1'b0, BASES[b] + 8'd3, {2'b00, nvm_normal_code[6*b +: 6]}, 1'b0);
      apb(1'b0, BASES[b] + 8'd4, 8'h06, 1'b0);
    end
    apb(1'b1, `BRC_IDX_B5_MODES, 8'hff, 1'b0);
    apb(1'b0, `BRC_IDX_B5_MODES, 8'h07, 1'b0);
    apb(1'b0, 8'h50, 8'h00, 1'b1);
    apb(1'b1, 8'h50, 8'hff, 1'b1);
    apb(1'b0, `BRC_IDX_B5_REQ, 8'h00, 1'b1, 2'b01);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      apb(1'b1, `BRC_IDX_B5_REQ, seed, 1'b0);
      apb(1'b0, `BRC_IDX_B5_REQ, {6'h00, seed[1:0]}, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `BRC_IDX_B5_REQ, i[7:0], 1'b0);
      chk(1'b0, REQX[i]);
    end
    apb(1'b1, `BRC_IDX_B5_REQ, 8'h01, 1'b0);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `BRC_IDX_B5_FORCE, FRC[i], 1'b0);
      apb(1'b0, `BRC_IDX_B5_FORCE, FRC[i], 1'b0);
      chk(1'b0, FRX[i]);
    end
    apb(1'b1, `BRC_IDX_B5_FORCE, 8'h4e, 1'b0);
    for (int i = 0; i < 3; i++) begin
      psm_state <= PSM[i];
      chk(1'b0, PSX[i]);
    end
    psm_state <= `BRC_PSM_ACTIVE;
    apb(1'b1, `BRC_IDX_B5_STEP, 8'h86, 1'b0);
    apb(1'b1, `BRC_IDX_B5_VOLT, 8'h21, 1'b0);
    chk(1'b1, 8'h21);
    apb(1'b1, `BRC_IDX_B5_FORCE, 8'h33, 1'b0);
    chk(1'b1, 8'h33);
    apb(1'b1, `BRC_IDX_B5_FORCE, 8'h73, 1'b0);
    chk(1'b1, 8'h21);
    apb(1'b1, `BRC_IDX_B5_STEP, 8'h02, 1'b0);
    apb(1'b1, `BRC_IDX_B5_VOLT, 8'h23, 1'b0);
    n = 0;
    while (buck_voltage_code[5:0] !== 6'h22 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    m = 0;
    while (buck_voltage_code[5:0] !== 6'h23 && m < 400) begin
      @(posedge pclk);
      m++;
    end
    cmp_out({7'h00, n >= 167 && n <= 199}, 8'h01);
    cmp_out({7'h00, m >= 197 && m <= 199}, 8'h01);
    repeat (250) @(posedge pclk);
    chk(1'b1, 8'h23);
    apb(1'b1, `BRC_IDX_B5_STEP, 8'h86, 1'b0);
    apb(1'b1, `BRC_IDX_B5_REQ, 8'h03, 1'b0);
    apb(1'b1, `BRC_IDX_B5_VOLT, 8'h00, 1'b0);
    apb(1'b0, `BRC_IDX_B5_REQ, 8'h00, 1'b0);
    apb(1'b1, `BRC_IDX_B5_VOLT, 8'h21, 1'b0);
    apb(1'b0, `BRC_IDX_B5_REQ, 8'h03, 1'b0);
    apb(1'b1, `BRC_IDX_B5_VOLT, 8'haa, 1'b0);
    pulse(3'b010);
    apb(1'b0, `BRC_IDX_B5_VOLT, 8'haa, 1'b0);
    apb(1'b0, `BRC_IDX_B5_MODES, 8'h05, 1'b0);
    apb(1'b0, `BRC_IDX_B5_STEP, 8'h06, 1'b0);
    apb(1'b1, `BRC_IDX_B5_VOLT, 8'h2a, 1'b0);
    pulse(3'b010);
    apb(1'b0, `BRC_IDX_B5_VOLT, {2'b00, nvm_normal_code[5:0]}, 1'b0);
    apb(1'b1, `BRC_IDX_B5_REQ, 8'h01, 1'b0);
    apb(1'b1, `BRC_IDX_B5_FORCE, 8'h55, 1'b0);
    pulse(3'b001);
    apb(1'b0, `BRC_IDX_B5_REQ, 8'h00, 1'b0);
    apb(1'b0, `BRC_IDX_B5_FORCE, {2'b00, nvm_force_code[5:0]}, 1'b0);
    apb(1'b1, `BRC_IDX_B1_VOLT, 8'h30, 1'b0);
    pulse(3'b100);
    apb(1'b0, `BRC_IDX_B1_VOLT, {2'b00, nvm_normal_code[11:6]}, 1'b0);
    for (int b = 1; b < 3; b++) begin
      apb(1'b1, BASES[b] + 8'd1, 8'h01, 1'b0);
      chk(1'b0, 8'h06, b);
      apb(1'b1, BASES[b] + 8'd4, 8'h86, 1'b0);
      chk(1'b1, {2'b00, nvm_force_code[6*b +: 6]}, b);
    end
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule
`default_nettype wire
